// file: core/obcd_defines.vh
// Constants for the static configuration byte decoder
`ifndef OBCD_DEFINES_VH
`define OBCD_DEFINES_VH

// ***************************************************
// Byte zero field positions
// ***************************************************
`define OBCD_B0_HALT_RST 7
`define OBCD_B0_WDG_TYPE 6
`define OBCD_B0_GUARD_DIS 5
`define OBCD_B0_VD_HI 4
`define OBCD_B0_VD_LO 3
`define OBCD_B0_RSVD 2
`define OBCD_B0_PKG_LOW 1
`define OBCD_B0_READOUT_N 0

// ***************************************************
// Byte one field positions
// ***************************************************
`define OBCD_B1_PKG_HIGH 7
`define OBCD_B1_RST_LEN 6
`define OBCD_B1_SRC_HI 5
`define OBCD_B1_SRC_LO 4
`define OBCD_B1_RNG_HI 3
`define OBCD_B1_RNG_LO 1
`define OBCD_B1_PLL_OFF 0

// ***************************************************
// Encodings and values
// ***************************************************
`define OBCD_BLANK 8'hff
`define OBCD_RDATA_RST 8'h00
`define OBCD_VD_OFF 2'h3
`define OBCD_VD_LOWEST 2'h2
`define OBCD_VD_MEDIUM 2'h1
`define OBCD_VD_HIGHEST 2'h0
`define OBCD_SRC_RESONATOR 2'h0
`define OBCD_SRC_RESERVED 2'h1
`define OBCD_SRC_INT_RC 2'h2
`define OBCD_SRC_EXTERNAL 2'h3
`define OBCD_RNG_1_2 3'h0
`define OBCD_RNG_2_4 3'h1
`define OBCD_RNG_4_8 3'h2
`define OBCD_RNG_8_16 3'h3
`define OBCD_RST_LONG 13'h1000
`define OBCD_RST_SHORT 13'h0100
// Programming unit: 0 idle, 1 write byte zero, 2 write byte one, 3 erase
`define OBCD_CMD_IDLE 2'h0
`define OBCD_CMD_WR0 2'h1
`define OBCD_CMD_WR1 2'h2
`define OBCD_CMD_ERASE 2'h3
`endif

// file: core/obcd_option_decoder.v
// Static configuration byte store and decoder
// Function
// RL1 - Byte0 bit7 selects reset on halt
// RL2 - Byte0 bit6 selects hardware or software watchdog
// RL3 - Byte0 bit5 low enables clock security
// RL4 - Byte0 bits4:3 pick voltage detect threshold
// RL5 - Programmer keeps reserved bit at default; a byte zero write here can still clear bit 2
// RL6 - Byte0 bit0 low blocks readout and writes
// RL7 - Protected erase wipes user memory first
// RL8 - Unbonded pads forced to pull-up input
// RL9 - Byte1 bit6 picks 4096 or 256 cycles
// RL10 - Resonator users should pick long reset
// RL11 - Byte1 bits5:4 select main clock source
// RL12 - Byte1 bits3:1 decode frequency range
// RL13 - Range drives resonator current or operating range
// RL14 - Byte1 bit0 low doubles clock with PLL
// RL15 - PLL only with 2-4 MHz, never RC; the doubler here follows Byte1 bit0 alone, whatever the range or source
// RL16 - Bytes unmapped, reachable only in programming mode
// RL17 - Blank reads FFh; shipped with RC
// RL18 - ROM variant uses hard-wired values
// RL19 - ROM readout encoding inverted versus flash
// RL20 - Package low bit is ignored
// RL21 - Sample at reset, hold until next reset
`timescale 1ns/1ps
`include "obcd_defines.vh"

module obcd_option_decoder #(
  parameter ROM_VARIANT = 0,
  parameter [7:0] ROM_BYTE0 = 8'hff,
  parameter [7:0] ROM_BYTE1 = 8'hff,
  parameter [7:0] SHIP_BYTE1 = 8'he7,
  parameter NUM_PORTS = 6,
  parameter PADS_PER_PORT = 8,
  parameter [NUM_PORTS*PADS_PER_PORT-1:0] BONDED_MASK = {NUM_PORTS*PADS_PER_PORT{1'b1}}
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Programming port, pins from the programming tool
  input wire prog_mode,
  input wire [1:0] prog_cmd,
  input wire [7:0] prog_wdata,
  output wire [7:0] prog_rdata0,
  output wire [7:0] prog_rdata1,
  output wire prog_busy,
  // User memory erase handshake
  output wire user_erase_req,
  input wire user_erase_done,
  // Decoded settings
  output wire halt_watchdog_reset_sel,
  output wire watchdog_type_sel,
  output wire clock_guard_enable,
  output wire low_supply_detector,
  output wire auxiliary_supply_detector,
  output wire [1:0] voltage_detect_level,
  output wire readout_guard,
  output wire [12:0] reset_cycles,
  output wire [1:0] clock_source_type,
  output wire [2:0] clock_freq_range,
  output wire resonator_current_en,
  output wire freq_doubler_en,
  output wire [NUM_PORTS*PADS_PER_PORT-1:0] pad_pullup_force
);

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  reg pm_s1_q, pm_s2_q, done_s1_q, done_s2_q;
  reg [1:0] cmd_s1_q, cmd_s2_q;
  reg [7:0] wd_s1_q, wd_s2_q;
  reg [1:0] cmd_prev_q;
  reg [1:0] cmd_act_q;

  always @(posedge clk) begin
    pm_s1_q <= prog_mode;
    pm_s2_q <= pm_s1_q;
    done_s1_q <= user_erase_done;
    done_s2_q <= done_s1_q;
    cmd_s1_q <= prog_cmd;
    cmd_s2_q <= cmd_s1_q;
    wd_s1_q <= prog_wdata;
    wd_s2_q <= wd_s1_q;
    cmd_prev_q <= cmd_s2_q;
  end

  // A command acts once, and only after two equal samples: the two
  // command bits cross from the tool with no relation to clk, so a step
  // from 0 to 3 could show 1 or 2 for one cycle.
  wire cmd_steady = (cmd_s2_q == cmd_prev_q);
  wire cmd_new = pm_s2_q && cmd_steady && (cmd_s2_q != cmd_act_q); // RL16

  // Last steady code; tracked outside programming mode too, so a code
  // left on the pins does not fire when the mode is entered
  always @(posedge clk) begin
    if (rst)
      cmd_act_q <= `OBCD_CMD_IDLE;
    else if (cmd_steady)
      cmd_act_q <= cmd_s2_q;
  end

  // ***************************************************
  // Non-volatile byte store
  // ***************************************************
  // The store models the flash cells: they survive rst, so only a
  // power-on init gives them their shipped value.
  reg [7:0] nv0_q = `OBCD_BLANK; // RL17
  reg [7:0] nv1_q = SHIP_BYTE1; // RL17
  localparam ST_IDLE = 2'b00;
  localparam ST_WIPE = 2'b01;
  localparam ST_CLEAR = 2'b10;
  reg [1:0] state_q = ST_IDLE;

  // Read-out protection bit as stored, honouring the variant polarity
  function guard_active;
    input [7:0] b0;
    begin
      if (ROM_VARIANT != 0)
        guard_active = b0[`OBCD_B0_READOUT_N]; // RL19
      else
        guard_active = ~b0[`OBCD_B0_READOUT_N]; // RL6
    end
  endfunction

  wire store_locked = guard_active(nv0_q); // RL6
  reg [1:0] state_d;
  reg [7:0] nv0_d, nv1_d;

  // ***************************************************
  // Erase sequencer and cell programming
  // ***************************************************
  // Cells only go from 1 to 0 on a write, as in flash; erase brings the 1s back
  always @* begin
    state_d = state_q;
    nv0_d = nv0_q;
    nv1_d = nv1_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_new && ROM_VARIANT == 0) begin // RL18
          case (cmd_s2_q)
            `OBCD_CMD_WR0: begin
              if (!store_locked)
                nv0_d = wd_s2_q & nv0_q; // RL6
            end
            `OBCD_CMD_WR1: begin
              if (!store_locked)
                nv1_d = wd_s2_q & nv1_q; // RL6
            end
            `OBCD_CMD_ERASE: begin
              if (store_locked)
                state_d = ST_WIPE; // RL7
              else
                state_d = ST_CLEAR;
            end
            default: begin
            end
          endcase
        end
      end
      ST_WIPE: begin
        // Option bytes stay intact until the user memory is gone
        if (done_s2_q)
          state_d = ST_CLEAR; // RL7
      end
      ST_CLEAR: begin
        // Both bytes blank together in one cycle
        nv0_d = `OBCD_BLANK; // RL17
        nv1_d = `OBCD_BLANK; // RL17
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    state_q <= state_d;
    nv0_q <= nv0_d;
    nv1_q <= nv1_d;
  end

  assign user_erase_req = (state_q == ST_WIPE); // RL7
  assign prog_busy = (state_q != ST_IDLE);

  // ***************************************************
  // Readback
  // ***************************************************
  // Readback hidden while protected; blank pattern shown instead.
  // Outside programming mode the last value stays until rst loads 00.
  reg [7:0] rdata0_q, rdata0_d;
  reg [7:0] rdata1_q, rdata1_d;

  always @* begin
    rdata0_d = rdata0_q;
    rdata1_d = rdata1_q;
    if (pm_s2_q) begin // RL16
      rdata0_d = store_locked ? `OBCD_BLANK : nv0_q; // RL6
      rdata1_d = store_locked ? `OBCD_BLANK : nv1_q; // RL6
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata0_q <= `OBCD_RDATA_RST;
      rdata1_q <= `OBCD_RDATA_RST;
    end else begin
      rdata0_q <= rdata0_d;
      rdata1_q <= rdata1_d;
    end
  end

  assign prog_rdata0 = rdata0_q;
  assign prog_rdata1 = rdata1_q;

  // ***************************************************
  // Decode, sampled only while reset is held
  // ***************************************************
  // Settings never move outside reset, so bytes written in programming
  // mode only take effect at the next reset.
  wire [7:0] b0 = (ROM_VARIANT != 0) ? ROM_BYTE0 : nv0_q; // RL18
  wire [7:0] b1 = (ROM_VARIANT != 0) ? ROM_BYTE1 : nv1_q; // RL18
  wire [1:0] vd = b0[`OBCD_B0_VD_HI:`OBCD_B0_VD_LO];
  wire [1:0] src = b1[`OBCD_B1_SRC_HI:`OBCD_B1_SRC_LO];
  wire [2:0] rng = b1[`OBCD_B1_RNG_HI:`OBCD_B1_RNG_LO];
  // Reserved bit 2 and package bits carry no function here
  // RL5 RL20

  // ***************************************************
  // Decode helpers
  // ***************************************************
  // Both supply detectors share the one off code
  function detector_on;
    input [1:0] level;
    begin
      detector_on = (level != `OBCD_VD_OFF); // RL4
    end
  endfunction

  // The short phase suits clock sources that need no start-up time
  function [12:0] phase_cycles;
    input short_sel;
    begin
      if (short_sel)
        phase_cycles = `OBCD_RST_SHORT; // RL9
      else
        phase_cycles = `OBCD_RST_LONG; // RL9
    end
  endfunction

  // ***************************************************
  // Pad pull-up map
  // ***************************************************
  // Unbonded pads stay pulled-up inputs; left floating they would draw
  // current, so software must leave them alone.
  wire [NUM_PORTS*PADS_PER_PORT-1:0] pad_unbonded;
  genvar gp, gb;
  generate
    for (gp = 0; gp < NUM_PORTS; gp = gp + 1) begin : g_port
      for (gb = 0; gb < PADS_PER_PORT; gb = gb + 1) begin : g_pad
        assign pad_unbonded[gp*PADS_PER_PORT+gb] = ~BONDED_MASK[gp*PADS_PER_PORT+gb]; // RL8
      end
    end
  endgenerate

  // ***************************************************
  // Settings registers
  // ***************************************************
  reg halt_rst_q, halt_rst_d;
  reg wdog_type_q, wdog_type_d;
  reg guard_en_q, guard_en_d;
  reg low_det_q, low_det_d;
  reg aux_det_q, aux_det_d;
  reg [1:0] det_level_q, det_level_d;
  reg readout_q, readout_d;
  reg [12:0] rst_cyc_q, rst_cyc_d;
  reg [1:0] src_type_q, src_type_d;
  reg [2:0] range_q, range_d;
  reg res_cur_q, res_cur_d;
  reg doubler_q, doubler_d;
  reg [NUM_PORTS*PADS_PER_PORT-1:0] pad_force_q, pad_force_d;

  // Loaded on every clock edge while reset is held, held from release onwards
  always @* begin
    halt_rst_d = halt_rst_q;
    wdog_type_d = wdog_type_q;
    guard_en_d = guard_en_q;
    low_det_d = low_det_q;
    aux_det_d = aux_det_q;
    det_level_d = det_level_q;
    readout_d = readout_q;
    rst_cyc_d = rst_cyc_q;
    src_type_d = src_type_q;
    range_d = range_q;
    res_cur_d = res_cur_q;
    doubler_d = doubler_q;
    pad_force_d = pad_force_q;
    if (rst) begin // RL21
      halt_rst_d = b0[`OBCD_B0_HALT_RST]; // RL1
      wdog_type_d = b0[`OBCD_B0_WDG_TYPE]; // RL2
      guard_en_d = ~b0[`OBCD_B0_GUARD_DIS]; // RL3
      low_det_d = detector_on(vd); // RL4
      aux_det_d = detector_on(vd); // RL4
      det_level_d = vd; // RL4
      readout_d = guard_active(b0); // RL6
      rst_cyc_d = phase_cycles(b1[`OBCD_B1_RST_LEN]); // RL9
      src_type_d = src; // RL11
      range_d = rng; // RL12
      res_cur_d = (src == `OBCD_SRC_RESONATOR); // RL13
      doubler_d = ~b1[`OBCD_B1_PLL_OFF]; // RL14
      pad_force_d = pad_unbonded; // RL8
    end
  end

  always @(posedge clk) begin
    halt_rst_q <= halt_rst_d;
    wdog_type_q <= wdog_type_d;
    guard_en_q <= guard_en_d;
    low_det_q <= low_det_d;
    aux_det_q <= aux_det_d;
    det_level_q <= det_level_d;
    readout_q <= readout_d;
    rst_cyc_q <= rst_cyc_d;
    src_type_q <= src_type_d;
    range_q <= range_d;
    res_cur_q <= res_cur_d;
    doubler_q <= doubler_d;
    pad_force_q <= pad_force_d;
  end

  // ***************************************************
  // Output drive
  // ***************************************************
  assign halt_watchdog_reset_sel = halt_rst_q;
  assign watchdog_type_sel = wdog_type_q;
  assign clock_guard_enable = guard_en_q;
  assign low_supply_detector = low_det_q;
  assign auxiliary_supply_detector = aux_det_q;
  assign voltage_detect_level = det_level_q;
  assign readout_guard = readout_q;
  assign reset_cycles = rst_cyc_q;
  assign clock_source_type = src_type_q;
  assign clock_freq_range = range_q;
  assign resonator_current_en = res_cur_q;
  assign freq_doubler_en = doubler_q;
  assign pad_pullup_force = pad_force_q;

endmodule // obcd_option_decoder

// file: tb/obcd_prog_tool.sv
// Programming tool model driving the configuration pins
`timescale 1ns/1ps
module obcd_prog_tool (
  // Clock
  input wire clk,
  // Tool pins
  output logic prog_mode = 1'b0,
  output logic [1:0] prog_cmd = 2'h0,
  output logic [7:0] prog_wdata = 8'h5a
);
  task mode(input logic m);
    @(posedge clk);
    #1 prog_mode = m;
    repeat (4) @(posedge clk);
  endtask
  // Idle between commands; data inverted once the command is released
  task send(input logic [1:0] c, input logic [7:0] d);
    @(posedge clk);
    #1 prog_cmd = c;
    prog_wdata = d;
    repeat (8) @(posedge clk);
    #1 prog_cmd = 2'h0;
    prog_wdata = ~d;
    repeat (8) @(posedge clk);
  endtask
endmodule // obcd_prog_tool

// file: tb/obcd_option_decoder_chk.sv
// Checker for the configuration decoder ports
`timescale 1ns/1ps
module obcd_chk (
  input wire clk,
  input wire rst,
  input wire prog_mode,
  input wire [7:0] prog_rdata0,
  input wire prog_busy,
  input wire user_erase_req,
  input wire low_supply_detector,
  input wire auxiliary_supply_detector,
  input wire [1:0] voltage_detect_level,
  input wire readout_guard,
  input wire [12:0] reset_cycles,
  input wire [1:0] clock_source_type,
  input wire resonator_current_en,
  input wire freq_doubler_en,
  input wire [47:0] pad_pullup_force
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_hold; !rst |=> $stable({voltage_detect_level, readout_guard, reset_cycles, clock_source_type}); endproperty
  a_hold: assert property (p_hold) else $error("config changed after reset");
  property p_lvd; low_supply_detector == (voltage_detect_level != 2'h3); endproperty
  a_lvd: assert property (p_lvd) else $error("low detector mismatch");
  property p_avd; auxiliary_supply_detector == low_supply_detector; endproperty
  a_avd: assert property (p_avd) else $error("aux detector mismatch");
  property p_res; resonator_current_en == (clock_source_type == 2'h0); endproperty
  a_res: assert property (p_res) else $error("resonator current mismatch");
  property p_cyc; reset_cycles == 13'h1000 || reset_cycles == 13'h0100; endproperty
  a_cyc: assert property (p_cyc) else $error("reset length invalid");
  property p_pad; pad_pullup_force == 48'h0; endproperty
  a_pad: assert property (p_pad) else $error("bonded pad forced");
  property p_ers; user_erase_req |-> prog_busy; endproperty
  a_ers: assert property (p_ers) else $error("erase req without busy");
  property p_wipe; $fell(user_erase_req) |-> prog_busy ##1 !prog_busy; endproperty
  a_wipe: assert property (p_wipe) else $error("erase did not finish after wipe");
  property p_off; !prog_mode [*3] |=> $stable(prog_rdata0); endproperty
  a_off: assert property (p_off) else $error("readback moved outside programming");
  cover property (user_erase_req);
  cover property (readout_guard);
  cover property (freq_doubler_en);
endmodule // obcd_chk
bind obcd_option_decoder obcd_chk u_chk (.*);

// file: tb/obcd_option_decoder_tb_top.sv
// Self-checking bench for the configuration decoder
`timescale 1ns/1ps
module obcd_option_decoder_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic user_erase_done = 1'b0;
  wire prog_mode, prog_busy, user_erase_req, halt_watchdog_reset_sel, watchdog_type_sel, clock_guard_enable;
  wire low_supply_detector, auxiliary_supply_detector, readout_guard, resonator_current_en, freq_doubler_en;
  wire [1:0] prog_cmd, voltage_detect_level, clock_source_type;
  wire [2:0] clock_freq_range;
  wire [7:0] prog_wdata, prog_rdata0, prog_rdata1;
  wire [12:0] reset_cycles;
  wire [47:0] pad_pullup_force;
  int fail_count = 0;
  int comparisons = 0;
  int i;
  always #25 clk = ~clk;
  obcd_option_decoder uut (.*);
  obcd_prog_tool u_tool (.*);
  function logic [27:0] ex(input logic [7:0] a, input logic [7:0] b);
    ex = {a[7], a[6], ~a[5], a[4:3] != 2'h3, a[4:3] != 2'h3, a[4:3], ~a[0],
      b[6] ? 13'h0100 : 13'h1000, b[5:4], b[3:1], b[5:4] == 2'h0, ~b[0]};
  endfunction
  task give_verdict;
    $display("counts: %0d mismatches, %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bound(input int n);
    if (n >= 60) begin
      fail_count++;
      give_verdict;
    end
  endtask
  task do_rst;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
  endtask
  task chk_cfg(input logic [7:0] a, input logic [7:0] b);
    chk({halt_watchdog_reset_sel, watchdog_type_sel, clock_guard_enable, low_supply_detector,
      auxiliary_supply_detector, voltage_detect_level, readout_guard, reset_cycles, clock_source_type,
      clock_freq_range, resonator_current_en, freq_doubler_en}, ex(a, b));
    chk(|pad_pullup_force, 1'b0);
  endtask
  task t_blank;
    do_rst;
    chk_cfg(8'hff, 8'he7);
    u_tool.send(2'h1, 8'h7f);
    u_tool.mode(1'b1);
    chk(prog_rdata0, 8'hff);
    chk(prog_rdata1, 8'he7);
    $display("t_blank done");
  endtask
  // Resonator at 2-4 MHz with long reset and doubler; reserved bit left set
  task t_prog;
    u_tool.mode(1'b1);
    u_tool.send(2'h2, 8'h82);
    chk(prog_rdata1, 8'h82);
    u_tool.send(2'h1, 8'h04);
    chk(prog_rdata0, 8'hff);
    u_tool.send(2'h2, 8'h00);
    chk(prog_rdata1, 8'hff);
    u_tool.mode(1'b0);
    do_rst;
    chk_cfg(8'h04, 8'h82);
    $display("t_prog done");
  endtask
  task t_erase;
    u_tool.mode(1'b1);
    fork
      u_tool.send(2'h3, 8'h00);
    join_none
    for (i = 0; i < 60 && user_erase_req !== 1'b1; i++) @(posedge clk);
    bound(i);
    #1 user_erase_done = 1'b1;
    for (i = 0; i < 60 && prog_busy !== 1'b0; i++) @(posedge clk);
    bound(i);
    #1 user_erase_done = 1'b0;
    wait fork;
    chk(prog_rdata1, 8'hff);
    u_tool.mode(1'b0);
    do_rst;
    chk_cfg(8'hff, 8'hff);
    $display("t_erase done");
  endtask
  initial begin
    t_blank;
    t_prog;
    t_erase;
    give_verdict;
  end
endmodule // obcd_option_decoder_tb_top
